// [hdl/dph_pkg.sv]
// Notes on behaviour
// - First protocol seen after power-up, SPI or I2C, is locked; the other is ignored.
// - Four-wire SPI exists only while the general-purpose pin is mapped as serial output.
// - Serial input is sampled on serial clock falling edges while frame select is low.
// - A frame is 24 bits; frames with fewer falling edges are discarded.
// - In three-wire mode only the first 24 bits of a longer frame are used.
// - With frame select high, clock and data are blocked and the output floats.
// - Bit 23 is direction, bits 22-16 the address, bits 15-0 the data word.
// - Reads need serial_out_enable; a second frame shifts out the requested data.
// - The readback frame echoes the previous direction bit and address ahead of data.
// - Output data launches on the falling or rising clock edge per output_edge_select.
// - In four-wire mode a multiple-of-24 frame uses its last 24 bits.
// - In four-wire mode a frame not a multiple of 24 edges is discarded.
// - The I2C target answers 7-bit addresses only, never 10-bit addressing.
// - Standard, fast and fast-plus rates all use the same protocol.
// - Start, byte 0x00, byte 0x06, stop performs a full software reset.
// - The general-call reset asserts on the rising clock of the second byte's acknowledge.
// - Receiver acknowledges each byte by holding data low during the ninth clock high.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Acknowledge only a matching address; after stop release the bus and wait.
// - The receiving side acknowledges each data byte: device on writes, controller on reads.
// - Write is address, command, upper and lower byte; update at final acknowledge fall.
// - Target address is 1001, a fixed zero, then two bits from the select pin, sampled in byte one.
// - Read is address write, command, repeated start with read, upper then lower byte.
// - The broadcast address is answered regardless of the pin, for writes only.
package dph_pkg;

  // Serial frame layout.
  localparam logic [4:0] FRAME_BITS   = 5'h18;
  localparam logic [4:0] FRAME_LAST   = 5'h17;
  localparam int         RW_BIT       = 23;
  localparam int         ADDR_MSB     = 22;
  localparam int         ADDR_LSB     = 16;
  localparam int         DATA_MSB     = 15;
  localparam logic       DIR_WRITE    = 1'h0;

  // Two-wire bus constants.
  localparam logic [3:0] I2C_FIXED    = 4'h9;
  localparam logic [6:0] I2C_BCAST    = 7'h47;
  localparam logic [6:0] I2C_GENCALL  = 7'h00;
  localparam logic [7:0] GC_RESET     = 8'h06;
  localparam logic [3:0] BYTE_LAST    = 4'h7;
  localparam logic [3:0] ACK_SLOT     = 4'h8;

  typedef enum logic [1:0] {
    P_NONE = 2'b00,
    P_SPI  = 2'b01,
    P_I2C  = 2'b10
  } dph_proto_e;

  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_CMD  = 4'b0010,
    I_DHI  = 4'b0011,
    I_DLO  = 4'b0100,
    I_THI  = 4'b0101,
    I_TLO  = 4'b0110,
    I_GC   = 4'b0111,
    I_SKIP = 4'b1000
  } dph_i2c_e;

  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] data;
  } dph_wr_s;

endpackage : dph_pkg

// [hdl/dph_sync.sv]
`timescale 1ns/10ps
// Two-flop synchroniser; the first stage feeds only the second.
module dph_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // Both stages reset to the idle level so no false edge appears after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : dph_sync

// [hdl/dph_host_port.sv]
`timescale 1ns/10ps
module dph_host_port (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              spi_sync_n,
  input  wire logic              spi_sclk,
  input  wire logic              spi_sdi,
  output logic                   spi_sdo,
  output logic                   spi_sdo_oe,
  input  wire logic              i2c_scl,
  input  wire logic              i2c_sda_in,
  output logic                   i2c_sda_out,
  output logic                   i2c_sda_oe,
  input  wire logic [1:0]        addr_select_pin,
  input  wire logic              gpio_sdo_map,
  input  wire logic              serial_out_enable,
  input  wire logic              output_edge_select,
  output logic                   reg_wr_valid,
  output dph_pkg::dph_wr_s       reg_wr,
  output logic                   reg_rd_valid,
  output logic [6:0]             reg_rd_addr,
  input  wire logic [15:0]       reg_rd_data,
  output logic                   soft_reset,
  output dph_pkg::dph_proto_e    proto
);

  logic       sync_n_s, sclk_s, sdi_s, scl_s, sda_s;
  logic [1:0] a0_s;
  logic       sync_p, sclk_p, scl_p, sda_p;

  // Every pin crosses into core_clk through two flops; idle levels are high, except the select pin, which resets low.
  dph_sync #(.W(7), .INIT(7'h7C)) u_sync (
    .clk (core_clk),
    .rst (rst),
    .d   ({spi_sync_n, spi_sclk, spi_sdi, i2c_scl, i2c_sda_in, addr_select_pin}),
    .q   ({sync_n_s, sclk_s, sdi_s, scl_s, sda_s, a0_s})
  );

  // Previous samples for edge detection, taken from the synchronised copies.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_p <= 1'h1;
      sclk_p <= 1'h1;
      scl_p  <= 1'h1;
      sda_p  <= 1'h1;
    end else begin
      sync_p <= sync_n_s;
      sclk_p <= sclk_s;
      scl_p  <= scl_s;
      sda_p  <= sda_s;
    end
  end

  logic spi_ok, spi_active, spi_start, spi_end, sclk_fall, sclk_rise;
  logic four_wire, i2c_ok, i2c_start, i2c_stop, scl_rise, scl_fall;

  // Clock and data are ignored outside a frame, and in the other protocol once locked.
  assign spi_ok     = (proto != dph_pkg::P_I2C);
  assign spi_active = spi_ok && !sync_n_s;
  assign spi_start  = spi_ok && sync_p && !sync_n_s;
  assign spi_end    = spi_ok && !sync_p && sync_n_s;
  assign sclk_fall  = spi_active && sclk_p && !sclk_s;
  assign sclk_rise  = spi_active && !sclk_p && sclk_s;
  assign four_wire  = gpio_sdo_map;
  assign i2c_ok     = (proto != dph_pkg::P_SPI);
  assign i2c_start  = i2c_ok && scl_s && scl_p && sda_p && !sda_s;
  assign i2c_stop   = i2c_ok && scl_s && scl_p && !sda_p && sda_s;
  assign scl_rise   = i2c_ok && scl_s && !scl_p;
  assign scl_fall   = i2c_ok && !scl_s && scl_p;

  // The first protocol to show activity wins until the next power cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      proto <= dph_pkg::P_NONE;
    end else if (proto == dph_pkg::P_NONE) begin
      if (spi_start) begin
        proto <= dph_pkg::P_SPI;
      end else if (i2c_start) begin
        proto <= dph_pkg::P_I2C;
      end
    end
  end

  logic [4:0]  edge_cnt;
  logic [4:0]  mod_cnt;
  logic [23:0] in_word;
  logic [23:0] out_word;
  logic [7:0]  echo;
  logic        echo_rd, load_pending, frame_ok, spi_wr_fire, spi_rd_fire;

  // Edge count saturates at one frame; mod_cnt tracks whole frames for chains.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_cnt <= 5'h00;
      mod_cnt  <= 5'h00;
    end else if (spi_start) begin
      edge_cnt <= 5'h00;
      mod_cnt  <= 5'h00;
    end else if (sclk_fall) begin
      if (edge_cnt != dph_pkg::FRAME_BITS) begin
        edge_cnt <= edge_cnt + 5'h01;
      end
      mod_cnt <= (mod_cnt == dph_pkg::FRAME_LAST) ? 5'h00 : mod_cnt + 5'h01;
    end
  end

  // Three-wire keeps the first bits by freezing; four-wire keeps shifting for the last bits.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_word <= 24'h000000;
    end else if (sclk_fall && (four_wire || edge_cnt != dph_pkg::FRAME_BITS)) begin
      in_word <= {in_word[22:0], sdi_s};
    end
  end

  // Short frames always drop; four-wire also drops a partial trailing frame.
  assign frame_ok    = (edge_cnt == dph_pkg::FRAME_BITS)
                    && (!four_wire || mod_cnt == 5'h00);
  assign spi_wr_fire = spi_end && frame_ok && (in_word[dph_pkg::RW_BIT] == dph_pkg::DIR_WRITE);
  assign spi_rd_fire = spi_end && frame_ok && in_word[dph_pkg::RW_BIT] && serial_out_enable;

  // An accepted frame primes the output word for the next frame.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      load_pending <= 1'h0;
      echo         <= 8'h00;
      echo_rd      <= 1'h0;
    end else begin
      load_pending <= spi_wr_fire || spi_rd_fire;
      if (spi_wr_fire || spi_rd_fire) begin
        echo    <= in_word[dph_pkg::RW_BIT:dph_pkg::ADDR_LSB];
        echo_rd <= spi_rd_fire;
      end
    end
  end

  // Output word: echo plus read data, then shifts input through for daisy chains.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_word <= 24'h000000;
    end else if (load_pending) begin
      out_word <= {echo, echo_rd ? reg_rd_data : 16'h0000};
    end else if (sclk_fall) begin
      out_word <= {out_word[22:0], sdi_s};
    end
  end

  // The bit is launched on the edge chosen; the first bit shows at frame start.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spi_sdo <= 1'h0;
    end else if (spi_start) begin
      spi_sdo <= out_word[dph_pkg::RW_BIT];
    end else if (sclk_fall && !output_edge_select) begin
      spi_sdo <= out_word[dph_pkg::RW_BIT-1];
    end else if (sclk_rise && output_edge_select) begin
      spi_sdo <= out_word[dph_pkg::RW_BIT];
    end
  end

  // Drive only inside a four-wire frame so other chips can share the line.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spi_sdo_oe <= 1'h0;
    end else begin
      spi_sdo_oe <= spi_active && four_wire;
    end
  end

  dph_pkg::dph_i2c_e i2c_state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic [6:0]  cmd;
  logic [7:0]  data_hi;
  logic [15:0] rd_hold;
  logic [1:0]  a0_lat;
  logic        ack_ok, skip_fall, own_hit, bc_hit, gc_hit, addr_hit;
  logic        gc_fire, i2c_wr_fire, i2c_rd_fire;

  // Address decode; a 10-bit header never matches these patterns.
  assign own_hit  = (rx[7:1] == {dph_pkg::I2C_FIXED, 1'h0, a0_lat});
  assign bc_hit   = (rx[7:1] == dph_pkg::I2C_BCAST) && !rx[0];
  assign gc_hit   = (rx[7:1] == dph_pkg::I2C_GENCALL) && !rx[0];
  assign addr_hit = own_hit || bc_hit || gc_hit;
  assign gc_fire  = scl_rise && (bit_cnt == dph_pkg::ACK_SLOT)
                 && (i2c_state == dph_pkg::I_GC) && (rx == dph_pkg::GC_RESET);
  assign i2c_wr_fire = scl_fall && (bit_cnt == dph_pkg::ACK_SLOT) && (i2c_state == dph_pkg::I_DLO);
  assign i2c_rd_fire = scl_fall && (bit_cnt == dph_pkg::BYTE_LAST) && (i2c_state == dph_pkg::I_ADDR)
                    && own_hit && rx[0];

  // Read data is held so the two returned bytes come from one register value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_hold <= 16'h0000;
    end else if (reg_rd_valid) begin
      rd_hold <= reg_rd_data;
    end
  end

  // Byte engine; sampling at 50 MHz covers every bus rate with one protocol.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      i2c_state  <= dph_pkg::I_IDLE;
      bit_cnt    <= 4'h0;
      rx         <= 8'h00;
      tx         <= 8'h00;
      cmd        <= 7'h00;
      data_hi    <= 8'h00;
      a0_lat     <= 2'h0;
      ack_ok     <= 1'h0;
      skip_fall  <= 1'h0;
      i2c_sda_oe <= 1'h0;
    end else if (i2c_stop) begin
      i2c_state  <= dph_pkg::I_IDLE;
      bit_cnt    <= 4'h0;
      skip_fall  <= 1'h0;
      i2c_sda_oe <= 1'h0;
    end else if (i2c_start) begin
      i2c_state  <= dph_pkg::I_ADDR;
      bit_cnt    <= 4'h0;
      skip_fall  <= 1'h1;                                                 // The clock fall after a start is no data bit.
      i2c_sda_oe <= 1'h0;
    end else if (scl_rise) begin
      // Data is stable while the clock is high, so it is taken at the rise.
      if (bit_cnt != dph_pkg::ACK_SLOT) begin
        rx <= {rx[6:0], sda_s};
      end else begin
        ack_ok <= !sda_s;
      end
      if (i2c_state == dph_pkg::I_ADDR && bit_cnt == 4'h0) begin
        a0_lat <= a0_s;
      end
    end else if (scl_fall && skip_fall) begin
      skip_fall <= 1'h0;
    end else if (scl_fall) begin
      if (bit_cnt == dph_pkg::BYTE_LAST) begin
        bit_cnt <= dph_pkg::ACK_SLOT;
        unique case (i2c_state)
          dph_pkg::I_ADDR:  i2c_sda_oe <= addr_hit && !(bc_hit && rx[0]);
          dph_pkg::I_CMD,
          dph_pkg::I_DHI,
          dph_pkg::I_DLO:   i2c_sda_oe <= 1'h1;
          dph_pkg::I_GC:    i2c_sda_oe <= (rx == dph_pkg::GC_RESET);
          default:          i2c_sda_oe <= 1'h0;
        endcase
      end else if (bit_cnt == dph_pkg::ACK_SLOT) begin
        bit_cnt    <= 4'h0;
        i2c_sda_oe <= 1'h0;
        unique case (i2c_state)
          dph_pkg::I_ADDR: begin
            if (!addr_hit) begin
              i2c_state <= dph_pkg::I_SKIP;
            end else if (rx[0] && own_hit) begin
              i2c_state  <= dph_pkg::I_THI;
              tx         <= rd_hold[15:8];
              i2c_sda_oe <= !rd_hold[15];
            end else if (rx[0]) begin
              i2c_state <= dph_pkg::I_SKIP;
            end else begin
              i2c_state <= gc_hit ? dph_pkg::I_GC : dph_pkg::I_CMD;
            end
          end
          dph_pkg::I_CMD: begin
            cmd       <= rx[6:0];
            i2c_state <= dph_pkg::I_DHI;
          end
          dph_pkg::I_DHI: begin
            data_hi   <= rx;
            i2c_state <= dph_pkg::I_DLO;
          end
          dph_pkg::I_DLO:  i2c_state <= dph_pkg::I_DHI;
          dph_pkg::I_THI: begin
            if (ack_ok) begin
              i2c_state  <= dph_pkg::I_TLO;
              tx         <= rd_hold[7:0];
              i2c_sda_oe <= !rd_hold[7];
            end else begin
              i2c_state <= dph_pkg::I_SKIP;
            end
          end
          default:         i2c_state <= dph_pkg::I_SKIP;
        endcase
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        if (i2c_state == dph_pkg::I_THI || i2c_state == dph_pkg::I_TLO) begin
          tx         <= {tx[6:0], 1'h0};
          i2c_sda_oe <= !tx[6];
        end
      end
    end
  end

  // The pad only ever pulls low; the level itself is a constant flop.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      i2c_sda_out <= 1'h0;
    end else begin
      i2c_sda_out <= 1'h0;
    end
  end

  // Register-side strobes; the protocol lock keeps the two sources exclusive.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_wr_valid <= 1'h0;
      reg_wr       <= '0;
      reg_rd_valid <= 1'h0;
      reg_rd_addr  <= 7'h00;
      soft_reset   <= 1'h0;
    end else begin
      reg_wr_valid <= spi_wr_fire || i2c_wr_fire;
      reg_rd_valid <= spi_rd_fire || i2c_rd_fire;
      soft_reset   <= gc_fire;
      if (spi_wr_fire) begin
        reg_wr <= {in_word[dph_pkg::ADDR_MSB:dph_pkg::ADDR_LSB], in_word[dph_pkg::DATA_MSB:0]};
      end else if (i2c_wr_fire) begin
        reg_wr <= {cmd, data_hi, rx};
      end
      if (spi_rd_fire) begin
        reg_rd_addr <= in_word[dph_pkg::ADDR_MSB:dph_pkg::ADDR_LSB];
      end else if (i2c_rd_fire) begin
        reg_rd_addr <= cmd;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  proto_lock_a:  assert property (proto != dph_pkg::P_NONE |=> proto == $past(proto))
    else $error("Locked protocol changed.");
  sdo_idle_a:    assert property (sync_n_s |=> !spi_sdo_oe)
    else $error("Serial output driven outside a frame.");
  sdo_3wire_a:   assert property (!four_wire |=> !spi_sdo_oe)
    else $error("Serial output driven in three-wire mode.");
  short_drop_a:  assert property (spi_end && edge_cnt < dph_pkg::FRAME_BITS |=> !reg_wr_valid && !reg_rd_valid)
    else $error("Short frame was acted upon.");
  first_bits_a:  assert property (!four_wire && sclk_fall && edge_cnt == dph_pkg::FRAME_BITS
                                  |=> in_word == $past(in_word))
    else $error("Three-wire frame kept bits past the first frame.");
  chain_drop_a:  assert property (spi_end && four_wire && mod_cnt != 5'h00 |=> !reg_wr_valid && !reg_rd_valid)
    else $error("Partial chained frame was acted upon.");
  spi_write_a:   assert property (spi_wr_fire |=> reg_wr_valid && reg_wr.addr == $past(in_word[22:16])
                                  && reg_wr.data == $past(in_word[15:0]))
    else $error("Write strobe fields do not match the frame.");
  read_gate_a:   assert property (spi_end && !serial_out_enable |=> !reg_rd_valid)
    else $error("Read taken without serial output enabled.");
  echo_word_a:   assert property (load_pending |=> out_word[23:16] == $past(echo))
    else $error("Readback frame lacks the echo.");
  launch_edge_a: assert property (sclk_rise && !output_edge_select && !spi_start |=> spi_sdo == $past(spi_sdo))
    else $error("Output launched on the wrong edge.");
  gc_reset_a:    assert property (gc_fire |=> soft_reset ##1 !soft_reset)
    else $error("General-call reset pulse missing.");
  addr_nak_a:    assert property (scl_fall && bit_cnt == dph_pkg::BYTE_LAST && i2c_state == dph_pkg::I_ADDR
                                  && !addr_hit |=> !i2c_sda_oe)
    else $error("Acknowledged a foreign address.");
  stop_free_a:   assert property (i2c_stop |=> !i2c_sda_oe && i2c_state == dph_pkg::I_IDLE)
    else $error("Bus not released after stop.");
  i2c_update_a:  assert property (i2c_wr_fire |=> reg_wr_valid && reg_wr.addr == $past(cmd))
    else $error("Two-wire update missing at final acknowledge.");

endmodule : dph_host_port

// [testbench/dph_spi_host.sv]
`timescale 1ns/10ps
// Behavioural serial host; its clock idles high and stands still between frames.
module dph_spi_host (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic sel,
  output logic      sync_n,
  output logic      sclk,
  output logic      sdi
);
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    sdi    = 1'b0;
  end
  // Half a link period is four core cycles, so the link runs at 160 ns.
  task automatic half;
    repeat (4) @(posedge clk);
    #1;
  endtask : half
  // Sends n bits MSB first and records the first 24 output bits.
  task automatic xfer(input int n, input logic [47:0] bits, output logic [23:0] rx);
    sync_n = 1'b0;
    half();
    for (int k = 0; k < n; k++) begin
      sdi = bits[n-1-k];
      half();
      if (!sel && k < 24) rx[23-k] = sdo;
      sclk = 1'b0; // The device takes the input bit on this fall.
      half();
      if (sel && k < 24) rx[23-k] = sdo;
      sclk = 1'b1;
    end
    half();
    sync_n = 1'b1;
    sdi    = ~sdi; // A released line must not keep showing the last bit.
  endtask : xfer
endmodule : dph_spi_host

// [testbench/dph_host_port_tb.sv]
`timescale 1ns/10ps
module dph_host_port_tb;
  logic                core_clk = 1'b0;
  logic                rst      = 1'b1;
  logic                sync_n, sclk, sdi, sdo, sdo_oe, scl, sda_c, sda_out, sda_oe, sda_line;
  logic                gpio, soe, oes, wr_v, rd_v, srst;
  logic [1:0]          pin;
  logic [6:0]          rd_a;
  logic [15:0]         rd_d;
  logic [23:0]         rx;
  dph_pkg::dph_wr_s    wr;
  dph_pkg::dph_proto_e proto;
  int                  wr_cnt, rd_cnt, sr_cnt, oe_bad, bad_count, n_checks;

  always #10 core_clk = ~core_clk;
  // Open-drain data line: the device only ever pulls low.
  assign sda_line = sda_oe ? sda_out : sda_c;
  assign rd_d     = {9'h15A, rd_a};

  dph_spi_host u_host (.clk(core_clk), .sdo(sdo), .sel(oes), .sync_n(sync_n), .sclk(sclk), .sdi(sdi));
  dph_host_port u_dut (.core_clk(core_clk), .rst(rst), .spi_sync_n(sync_n), .spi_sclk(sclk), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .i2c_scl(scl), .i2c_sda_in(sda_line), .i2c_sda_out(sda_out),
    .i2c_sda_oe(sda_oe), .addr_select_pin(pin), .gpio_sdo_map(gpio), .serial_out_enable(soe),
    .output_edge_select(oes), .reg_wr_valid(wr_v), .reg_wr(wr), .reg_rd_valid(rd_v), .reg_rd_addr(rd_a),
    .reg_rd_data(rd_d), .soft_reset(srst), .proto(proto));

  // Strobes are counted so a scenario can tell a refused frame from an accepted one.
  always @(posedge core_clk) begin
    if (wr_v === 1'b1) wr_cnt++;
    if (rd_v === 1'b1) rd_cnt++;
    if (srst === 1'b1) sr_cnt++;
    if (gpio === 1'b0 && sdo_oe !== 1'b0) oe_bad++;
  end

  initial begin
    {gpio, soe, oes, scl, sda_c} = 5'h03;
    pin = 2'h1;
  end

  task automatic dly(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : dly
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  // Reset stands in for a power cycle, which also frees the protocol choice.
  task automatic do_reset;
    rst = 1'b1;
    dly(12);
    rst = 1'b0;
    dly(2);
  endtask : do_reset
  task automatic spi(input int n, input logic [47:0] b);
    u_host.xfer(n, b, rx);
    dly(10);
  endtask : spi
  function automatic logic [15:0] rv(input logic [6:0] a);
    return {9'h15A, a};
  endfunction : rv
  // Data changes only while the clock is low, and is sampled mid-high.
  task automatic ibit(input logic b, output logic r);
    sda_c = b;
    dly(25);
    scl = 1'b1;
    dly(12);
    r = sda_line;
    dly(13);
    scl = 1'b0;
  endtask : ibit
  task automatic istart;
    sda_c = 1'b1;
    dly(12);
    scl = 1'b1;
    dly(12);
    sda_c = 1'b0;
    dly(12);
    scl = 1'b0;
  endtask : istart
  task automatic istop;
    sda_c = 1'b0;
    dly(12);
    scl = 1'b1;
    dly(12);
    sda_c = 1'b1;
    dly(12);
  endtask : istop
  task automatic ibyte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) ibit(b[i], r);
    ibit(1'b1, nak);
  endtask : ibyte
  // The device drives eight bits; the controller answers in the ninth clock.
  task automatic iread(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) ibit(1'b1, d[i]);
    ibit(ack, r);
  endtask : iread

  task automatic t_spi_write;
    int w;
    w = wr_cnt;
    spi(24, 48'h12ABCD);
    chk(wr_cnt == w + 1 && wr === {7'h12, 16'hABCD}, "plain write");
    chk(proto === dph_pkg::P_SPI, "lock to serial");
    spi(23, 48'h05FFFF);
    chk(wr_cnt == w + 1, "short frame taken");
    $display("test spi_write done");
  endtask : t_spi_write
  task automatic t_spi_frames;
    int w;
    spi(30, {24'h345678, 6'h2A});
    chk(wr === {7'h34, 16'h5678} && oe_bad == 0, "long three-wire frame");
    gpio = 1'b1;
    spi(48, {24'hFFFFFF, 24'h0A1234});
    chk(wr === {7'h0A, 16'h1234}, "chained frame");
    w = wr_cnt;
    spi(30, {24'h0B1111, 6'h00});
    chk(wr_cnt == w, "odd edge count taken");
    $display("test spi_frames done");
  endtask : t_spi_frames
  task automatic t_spi_read;
    int r;
    soe = 1'b1;
    r = rd_cnt;
    spi(24, 48'h9B0000);
    chk(rd_cnt == r + 1 && rd_a === 7'h1B, "read request");
    spi(24, 48'hAC0000);
    chk(rx === {1'b1, 7'h1B, rv(7'h1B)}, "readback on fall");
    oes = 1'b1;
    spi(24, 48'h9B0000);
    chk(rx === {1'b1, 7'h2C, rv(7'h2C)}, "readback on rise");
    soe = 1'b0;
    spi(24, 48'hAC0000);
    chk(rd_cnt == r + 3 && sdo_oe === 1'b0, "read without enable");
    $display("test spi_read done");
  endtask : t_spi_read
  task automatic t_lock_spi;
    logic n;
    istart();
    ibyte(8'h92, n);
    istop();
    chk(n === 1'b1 && proto === dph_pkg::P_SPI, "two-wire after serial lock");
    $display("test lock_spi done");
  endtask : t_lock_spi
  task automatic t_i2c;
    logic [7:0] bad_a [3] = '{8'h94, 8'h8F, 8'hF0};
    logic       n0, n1, n2, n3;
    int         w, s;
    logic [15:0] d;
    istart();
    ibyte(8'h92, n0);
    ibyte(8'h05, n1);
    ibyte(8'hBE, n2);
    w = wr_cnt;
    ibyte(8'hEF, n3);
    dly(10);
    istop();
    chk({n0, n1, n2, n3} === 4'h0, "write acks");
    chk(wr_cnt == w + 1 && wr === {7'h05, 16'hBEEF}, "two-wire write");
    chk(proto === dph_pkg::P_I2C, "lock to two-wire");
    istart();
    ibyte(8'h92, n0);
    ibyte(8'h1B, n1);
    istart();
    ibyte(8'h93, n2);
    iread(1'b0, d[15:8]);
    iread(1'b1, d[7:0]);
    istop();
    chk({n0, n1, n2} === 3'h0 && rd_a === 7'h1B && d === rv(7'h1B), "two-wire read");
    for (int i = 0; i < 3; i++) begin
      istart();
      ibyte(bad_a[i], n0);
      istop();
      chk(n0 === 1'b1, "foreign address acked");
    end
    istart();
    ibyte(8'h8E, n0);
    istop();
    chk(n0 === 1'b0, "broadcast write");
    s = sr_cnt;
    istart();
    ibyte(8'h00, n0);
    ibyte(8'h06, n1);
    chk(sr_cnt == s + 1 && {n0, n1} === 2'h0, "general call reset");
    istop();
    $display("test i2c done");
  endtask : t_i2c
  task automatic t_lock_i2c;
    int w;
    w = wr_cnt;
    spi(24, 48'h12ABCD);
    chk(wr_cnt == w && proto === dph_pkg::P_I2C, "serial after two-wire lock");
    $display("test lock_i2c done");
  endtask : t_lock_i2c
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    do_reset();
    t_spi_write();
    t_spi_frames();
    t_spi_read();
    t_lock_spi();
    do_reset();
    t_i2c();
    t_lock_i2c();
    conclude();
  end
endmodule : dph_host_port_tb
